// >>> logic/rbc_pkg.sv
// How it works
// - the clock command word is decoded at byte offset four only
// - ten byte buffer: sub-seconds, time, date fields, then leap and mode byte
// - read done: pending clears, addressed entry shown in low byte
// - entries zero and one always read back as zero
// - buffer write: hardware clear, write set; low byte stored at index
// - hardware set with write set copies buffer entries two to nine into the clock chip
// - hardware set with write clear copies the clock chip into buffer entries two to nine
// - entry nine bit zero selects 24-hour mode when one, 12-hour when zero
package rbc_pkg;
  localparam logic [11:0] CMD_ADDR = 12'h004;
  localparam int BUF_DEPTH = 10;
  localparam int IDX_W = 4;
  localparam int BIT_PEND = 15;
  localparam int BIT_CLK = 14;
  localparam int BIT_HW = 13;
  localparam int BIT_RW = 12;
  localparam int IDX_LSB = 8;
  localparam logic [3:0] IDX_SUB_LO = 4'h0;
  localparam logic [3:0] IDX_SUB_HI = 4'h1;
  localparam logic [3:0] IDX_LAST = 4'h9;
  localparam logic [3:0] IDX_MODE = 4'h9;
  localparam int MODE_24H_BIT = 0;
  localparam int MODE_PM_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    RBC_IDLE = 3'b000,
    RBC_READ = 3'b001,
    RBC_WRITE = 3'b010,
    RBC_TO_HW = 3'b011,
    RBC_FROM_HW = 3'b100
  } rbc_state_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [3:0] idx;
    logic [7:0] data;
  } rbc_chip_req_t;
endpackage : rbc_pkg

// >>> logic/rbc_mem.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_mem #(
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [7:0] wdata, // write byte
  input wire logic [AW-1:0] raddr, // read index
  output logic [7:0] rdata // registered read byte
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end
  always_ff @(posedge pclk) begin
    if (we && (32'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : rbc_mem
`default_nettype wire

// >>> logic/rbc_top.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rbc_top (
  input wire logic pclk, // clock, 100 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic chip_req, // clock chip byte request
  output logic chip_wr, // chip request direction
  output logic [3:0] chip_idx, // chip register index
  output logic [7:0] chip_wdata, // byte to chip
  input wire logic chip_ack, // chip done, same clock
  input wire logic [7:0] chip_rdata // byte from chip
);
  typedef struct packed {
    rbc_pkg::rbc_state_t st;
    logic pend;
    logic clk_sel;
    logic hw;
    logic rw;
    logic [3:0] idx;
    logic [7:0] value;
    logic [3:0] walk;
    logic wait_rd;
    rbc_pkg::rbc_chip_req_t chip;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rbc_regs_t;

  rbc_regs_t r;
  rbc_regs_t next_r;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [7:0] mem_rdata;

  function automatic logic is_sub(input logic [3:0] i);
    is_sub = (i == rbc_pkg::IDX_SUB_LO) || (i == rbc_pkg::IDX_SUB_HI);
  endfunction : is_sub

  function automatic logic [15:0] cmd_word(input rbc_regs_t s);
    cmd_word = {s.pend, s.clk_sel, s.hw, s.rw, s.idx, s.value};
  endfunction : cmd_word

  rbc_mem #(
    .DEPTH(rbc_pkg::BUF_DEPTH),
    .AW(rbc_pkg::IDX_W)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  logic setup;
  logic hit;
  assign setup = psel && !penable;
  assign hit = (paddr == rbc_pkg::CMD_ADDR);

  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_waddr = r.idx;
    mem_wdata = r.value;
    mem_raddr = r.idx;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // answer one cycle after setup: pready comes with the access phase
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !hit;
      next_r.prdata = 32'h0000_0000;
      if (hit && !pwrite) begin
        next_r.prdata = {16'h0000, cmd_word(r)};
      end
    end
    // writes land on the access-phase edge, as apb requires
    if (psel && penable && r.pready && pwrite && hit && !r.pend) begin
      next_r.clk_sel = pwdata[rbc_pkg::BIT_CLK];
      next_r.hw = pwdata[rbc_pkg::BIT_HW];
      next_r.rw = pwdata[rbc_pkg::BIT_RW];
      next_r.idx = pwdata[rbc_pkg::IDX_LSB +: rbc_pkg::IDX_W];
      next_r.value = pwdata[7:0];
      // only a pending plus clock-select word starts an operation
      if (pwdata[rbc_pkg::BIT_PEND] && pwdata[rbc_pkg::BIT_CLK]) begin
        next_r.pend = 1'b1;
        next_r.walk = 4'h0;
        next_r.wait_rd = 1'b0;
        if (!pwdata[rbc_pkg::BIT_HW] && !pwdata[rbc_pkg::BIT_RW]) begin
          next_r.st = rbc_pkg::RBC_READ;
        end else if (!pwdata[rbc_pkg::BIT_HW]) begin
          next_r.st = rbc_pkg::RBC_WRITE;
        end else if (pwdata[rbc_pkg::BIT_RW]) begin
          next_r.st = rbc_pkg::RBC_TO_HW;
        end else begin
          next_r.st = rbc_pkg::RBC_FROM_HW;
        end
      end
    end
    case (r.st)
      rbc_pkg::RBC_IDLE: begin
      end
      rbc_pkg::RBC_READ: begin
        // memory read is registered, so the byte arrives one cycle later
        if (!r.wait_rd) begin
          next_r.wait_rd = 1'b1;
        end else begin
          next_r.value = (is_sub(r.idx) || r.idx > rbc_pkg::IDX_LAST) ?
                         rbc_pkg::ZERO_BYTE : mem_rdata;
          next_r.pend = 1'b0;
          next_r.st = rbc_pkg::RBC_IDLE;
        end
      end
      rbc_pkg::RBC_WRITE: begin
        mem_we = (r.idx <= rbc_pkg::IDX_LAST);
        next_r.pend = 1'b0;
        next_r.st = rbc_pkg::RBC_IDLE;
      end
      rbc_pkg::RBC_TO_HW: begin
        // walk entries 2..9; sub-second entries are not held by the chip
        mem_raddr = r.walk;
        if (!r.chip.req) begin
          if (r.walk == 4'h0) begin
            next_r.walk = rbc_pkg::IDX_SUB_HI + 4'h1;
          end else if (!r.wait_rd) begin
            next_r.wait_rd = 1'b1;
          end else begin
            next_r.chip.req = 1'b1;
            next_r.chip.wr = 1'b1;
            next_r.chip.idx = r.walk;
            next_r.chip.data = mem_rdata;
          end
        end else if (chip_ack) begin
          next_r.chip.req = 1'b0;
          next_r.wait_rd = 1'b0;
          if (r.walk == rbc_pkg::IDX_LAST) begin
            next_r.pend = 1'b0;
            next_r.st = rbc_pkg::RBC_IDLE;
          end else begin
            next_r.walk = r.walk + 4'h1;
          end
        end
      end
      rbc_pkg::RBC_FROM_HW: begin
        if (!r.chip.req && !r.wait_rd) begin
          if (r.walk == 4'h0) begin
            next_r.walk = rbc_pkg::IDX_SUB_HI + 4'h1;
          end else begin
            next_r.chip.req = 1'b1;
            next_r.chip.wr = 1'b0;
            next_r.chip.idx = r.walk;
          end
        end else if (r.chip.req && chip_ack) begin
          next_r.chip.req = 1'b0;
          mem_we = 1'b1;
          mem_waddr = r.walk;
          mem_wdata = chip_rdata;
          if (r.walk == rbc_pkg::IDX_LAST) begin
            next_r.pend = 1'b0;
            next_r.st = rbc_pkg::RBC_IDLE;
          end else begin
            next_r.walk = r.walk + 4'h1;
          end
        end
      end
      default: begin
        next_r.st = rbc_pkg::RBC_IDLE;
        next_r.pend = 1'b0;
      end
    endcase
  end

  // mode byte is stored and forwarded as written; only the chip acts on its bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign chip_req = r.chip.req;
  assign chip_wr = r.chip.wr;
  assign chip_idx = r.chip.idx;
  assign chip_wdata = r.chip.data;

  // buffer read finish, bus answer and decode
  chk_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_READ && r.wait_rd)
    |=> !r.pend && r.st == rbc_pkg::RBC_IDLE)
    else $error("buffer read did not finish");
  chk_sub_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_READ && r.wait_rd && is_sub(r.idx))
    |=> r.value == rbc_pkg::ZERO_BYTE)
    else $error("sub-second entry read nonzero");
  chk_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr != rbc_pkg::CMD_ADDR)
    |=> pready && pslverr)
    else $error("unmapped access not refused");
  chk_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
    setup
    |=> pready)
    else $error("no ready after setup");
  chk_ready_only: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |-> $past(setup))
    else $error("ready without setup");
  chk_hit_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit)
    |=> pready && !pslverr)
    else $error("mapped access refused");
  chk_miss_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit)
    |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_read_word: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit && !pwrite)
    |=> prdata[31:16] == 16'h0000 && prdata[15] == $past(r.pend))
    else $error("command word read wrong");

  // command start and refusal
  chk_start_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && hit && !r.pend &&
     pwdata[rbc_pkg::BIT_PEND] && pwdata[rbc_pkg::BIT_CLK])
    |=> r.pend)
    else $error("clock command not started");
  chk_fields_only: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && hit && !r.pend &&
     !(pwdata[rbc_pkg::BIT_PEND] && pwdata[rbc_pkg::BIT_CLK]))
    |=> !r.pend && r.st == rbc_pkg::RBC_IDLE)
    else $error("operation started without both bits");
  chk_pend_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (r.pend && $past(r.pend) && r.st != rbc_pkg::RBC_IDLE)
    |-> $stable(r.hw) && $stable(r.rw))
    else $error("command changed while pending");
  chk_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && r.pend)
    |=> $stable(r.idx) && $stable(r.clk_sel))
    else $error("write taken while pending");
  chk_pend_state: assert property (@(posedge pclk) disable iff (!presetn)
    r.pend
    == (r.st != rbc_pkg::RBC_IDLE))
    else $error("pending flag out of step with state");

  // buffer and chip walks
  chk_read_slot: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_READ && !r.wait_rd)
    |-> mem_raddr == r.idx ##1 r.wait_rd)
    else $error("buffer read index wrong");
  chk_write_one: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_WRITE)
    |-> mem_we == (r.idx <= rbc_pkg::IDX_LAST) ##1 !r.pend)
    else $error("buffer write misbehaved");
  chk_write_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_WRITE)
    |-> mem_waddr == r.idx && mem_wdata == r.value)
    else $error("buffer write address or byte wrong");
  chk_idle_mem: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_IDLE)
    |-> !mem_we)
    else $error("buffer written while idle");
  chk_idle_free: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_IDLE)
    |-> !r.chip.req)
    else $error("chip request while idle");
  chk_chip_range: assert property (@(posedge pclk) disable iff (!presetn)
    r.chip.req
    |-> r.chip.idx > rbc_pkg::IDX_SUB_HI && r.chip.idx <= rbc_pkg::IDX_LAST)
    else $error("chip index outside time entries");
  chk_hw_dir: assert property (@(posedge pclk) disable iff (!presetn)
    r.chip.req
    |-> r.chip.wr == (r.st == rbc_pkg::RBC_TO_HW))
    else $error("chip direction wrong");
  chk_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (r.chip.req && !chip_ack)
    |=> r.chip.req && $stable(r.chip.idx) && $stable(r.chip.data))
    else $error("chip request changed before answer");
  chk_hw_done: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_TO_HW && r.chip.req && chip_ack && r.chip.idx == rbc_pkg::IDX_LAST)
    |=> !r.pend && r.st == rbc_pkg::RBC_IDLE)
    else $error("chip programming did not finish");
  chk_from_hw: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_FROM_HW && r.chip.req && chip_ack)
    |-> mem_we)
    else $error("chip byte not stored");
  chk_req_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (r.chip.req && chip_ack)
    |=> !r.chip.req)
    else $error("chip request held after answer");
  chk_mode_send: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_TO_HW && !r.chip.req && r.wait_rd && r.walk == rbc_pkg::IDX_MODE)
    |=> r.chip.req && r.chip.data == $past(mem_rdata))
    else $error("mode byte not sent as stored");
  chk_mode_take: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == rbc_pkg::RBC_FROM_HW && r.chip.req && chip_ack && r.walk == rbc_pkg::IDX_MODE)
    |-> mem_we && mem_waddr == rbc_pkg::IDX_MODE && mem_wdata == chip_rdata)
    else $error("mode byte not stored as read");
endmodule : rbc_top
`default_nettype wire

// >>> verification/rbc_chip_model.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_chip_model (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic chip_req, // byte request
  input wire logic chip_wr, // 1 write, 0 read
  input wire logic [3:0] chip_idx, // chip register index
  input wire logic [7:0] chip_wdata, // byte to chip
  output logic chip_ack, // request done
  output logic [7:0] chip_rdata, // byte from chip
  input wire logic [2:0] dly // answer delay in cycles
);
  logic [7:0] regs [10];
  logic [2:0] cnt;
  // plain always so the bench may preload the time registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_ack <= 1'b0;
      cnt <= 3'd0;
      chip_rdata <= 8'h00;
    end else begin
      chip_ack <= 1'b0;
      // data line is not held outside an answer
      chip_rdata <= ~chip_rdata;
      if (chip_req && !chip_ack) begin
        if (cnt == dly) begin
          cnt <= 3'd0;
          chip_ack <= 1'b1;
          if (chip_wr) regs[chip_idx] <= chip_wdata;
          else chip_rdata <= regs[chip_idx];
        end else begin
          cnt <= cnt + 3'd1;
        end
      end
    end
  end
endmodule : rbc_chip_model
`default_nettype wire

// >>> verification/rbc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, chip_req, chip_wr, chip_ack, err;
  logic [3:0] chip_idx;
  logic [7:0] chip_wdata, chip_rdata;
  logic [2:0] dly = 3'd0;
  logic [7:0] fv;
  logic [7:0] bm [10];
  int failures = 0, cmp_count = 0, k;
  always #5 pclk = ~pclk;
  rbc_top i_rbc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_req(chip_req), .chip_wr(chip_wr), .chip_idx(chip_idx),
    .chip_wdata(chip_wdata), .chip_ack(chip_ack), .chip_rdata(chip_rdata));
  rbc_chip_model i_rbc_chip_model (.pclk(pclk), .presetn(presetn), .chip_req(chip_req),
    .chip_wr(chip_wr), .chip_idx(chip_idx), .chip_wdata(chip_wdata), .chip_ack(chip_ack),
    .chip_rdata(chip_rdata), .dly(dly));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin chk(0, 1); summarize(); end
  endtask : apb
  // every clock command carries pending and select set
  function automatic logic [31:0] w(input logic hw, input logic rw, input logic [3:0] i,
    input logic [7:0] v);
    return {16'h0000, 2'b11, hw, rw, i, v};
  endfunction : w
  task automatic poll;
    int n;
    n = 0;
    do begin apb(1'b0, 12'h004, 32'h0000_0000); n++; end while (rd[15] !== 1'b0 && n < 80);
    if (n >= 80) begin chk(0, 1); summarize(); end
  endtask : poll
  task automatic rdall;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 12'h004, w(1'b0, 1'b0, 4'(i), 8'h00));
      poll();
      chk(rd[7:0], (i < 2) ? 8'h00 : bm[i]);
    end
  endtask : rdall
  initial begin
    k = $urandom(32'hcfa7);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 10; k++) begin
      bm[k] = $urandom;
      // mode byte: 24-hour, so the pm flag stays zero
      if (k == 9) bm[9] = {4'h0, 2'($urandom), 2'b01};
      apb(1'b1, 12'h004, w(1'b0, 1'b1, 4'(k), bm[k]));
      poll();
    end
    rdall();
    $display("test buffer done");
    apb(1'b1, 12'h008, w(1'b0, 1'b1, 4'h2, 8'h55));
    chk(err, 1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    rdall();
    $display("test decode done");
    // a word without pending and select only loads the fields
    fv = 8'($urandom);
    apb(1'b1, 12'h004, {16'h0000, 4'b0010, 4'h6, fv});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, {16'h0000, 4'b0010, 4'h6, fv});
    apb(1'b1, 12'h004, w(1'b0, 1'b1, 4'hc, fv));
    poll();
    apb(1'b1, 12'h004, w(1'b0, 1'b0, 4'hc, 8'h00));
    poll();
    chk(rd, {16'h0000, 4'b0100, 4'hc, 8'h00});
    rdall();
    $display("test field load done");
    dly <= 3'd3;
    apb(1'b1, 12'h004, w(1'b1, 1'b1, 4'h0, 8'h00));
    apb(1'b1, 12'h004, w(1'b0, 1'b1, 4'h2, ~bm[2]));
    poll();
    for (k = 2; k < 10; k++) chk(i_rbc_chip_model.regs[k], bm[k]);
    rdall();
    $display("test to clock chip done");
    dly <= 3'd0;
    for (k = 2; k < 10; k++) begin
      bm[k] = $urandom;
      i_rbc_chip_model.regs[k] = bm[k];
    end
    apb(1'b1, 12'h004, w(1'b1, 1'b0, 4'h0, 8'h00));
    poll();
    rdall();
    $display("test from clock chip done");
    // reset in mid-run clears the command word
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
endmodule : rbc_tb_top
`default_nettype wire
